// ---- rtl/cav_pkg.sv ----
package cav_pkg;

   // ****************************************************************
   // Sizes
   // ****************************************************************
   localparam int MODULE_COUNT = 6;

   // ****************************************************************
   // Register offsets on the special function register bus
   // ****************************************************************
   localparam logic [7:0] COUNTER_LOW_BYTE_OFS  = 8'hf9;
   localparam logic [7:0] COUNTER_HIGH_BYTE_OFS = 8'hfa;
   // Entry n belongs to module n
   localparam logic [5:0][7:0] MODULE_VALUE_LOW_OFS  = {8'hd2, 8'hfd, 8'hed, 8'heb, 8'he9, 8'hfb};
   localparam logic [5:0][7:0] MODULE_VALUE_HIGH_OFS = {8'hd3, 8'hfe, 8'hee, 8'hec, 8'hea, 8'hfc};

   // ****************************************************************
   // Values after reset
   // ****************************************************************
   localparam logic [7:0]  BYTE_RESET    = 8'h00;
   localparam logic [15:0] COUNTER_RESET = 16'h0000;
   localparam logic [15:0] VALUE_RESET   = 16'h0000;

   // ****************************************************************
   // Cycle length select encodings
   // ****************************************************************
   localparam logic [1:0] CYCLE_8_BITS  = 2'h0;
   localparam logic [1:0] CYCLE_9_BITS  = 2'h1;
   localparam logic [1:0] CYCLE_10_BITS = 2'h2;
   localparam logic [1:0] CYCLE_11_BITS = 2'h3;

   // Index of the module that serves as watchdog timer
   localparam int WATCHDOG_MODULE = 5;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef struct packed {
      logic [7:0] addr;
      logic       write;
      logic       read;
      logic [7:0] wdata;
   } cav_sfr_req_type;

   typedef struct packed {
      logic       hit;
      logic       high;
      logic [2:0] index;
   } cav_decode_type;

endpackage

// ---- rtl/cav_counter_array_value_regs.sv ----
`timescale 1ns/1ns
// Functional notes
// - Counter bits 7:0 readable and writable byte, reset zero.
// - Counter bits 15:8 readable and writable byte, reset zero.
// - High byte read returns snapshot taken when low byte is read.
// - Watchdog enabled: writes to counter low byte are ignored.
// - Watchdog enabled: writes to counter high byte are ignored.
// - Each module has a readable and writable value low byte, reset zero.
// - Each module has a readable and writable value high byte, reset zero.
// - Reload select steers low byte address to auto-reload low byte.
// - Reload select steers high byte address to auto-reload high byte.
// - Writing a module low byte clears its comparator enable.
// - Writing a module high byte sets its comparator enable.
// - Six modules, each with distinct low and high byte addresses.
// - Comparator enable turns on match against the main counter.
// - Cycle length select picks 8, 9, 10 or 11 bit PWM cycle for modules whose pwm16Select bit is clear; set bits give 16 bits.
// - Watchdog enabled: watchdogModuleActive flags module 5 as watchdog one cycle later.
module cav_counter_array_value_regs (
   input  wire logic                    clk_sys,
   input  wire logic                    rstn,
   input  wire cav_pkg::cav_sfr_req_type sfrReq,
   output logic [7:0]                   sfrRdata,
   input  wire logic                    watchdogEnable,
   input  wire logic                    reloadSelect,
   input  wire logic [1:0]              cycleLengthSelect,
   input  wire logic [5:0]              pwm16Select,
   input  wire logic                    counterTick,
   output logic [15:0]                  mainCounter,
   output logic [5:0][15:0]             moduleCompareValue,
   output logic [5:0][15:0]             moduleReloadValue,
   output logic [5:0]                   comparatorEnable,
   output logic [5:0]                   matchPulse,
   output logic                         watchdogModuleActive
);

   // ****************************************************************
   // Address decode
   // ****************************************************************
   function automatic cav_pkg::cav_decode_type decodeModule(input logic [7:0] addr);
      cav_pkg::cav_decode_type d;
      d = '0;
      for (int i = 0; i < cav_pkg::MODULE_COUNT; i++) begin
         if (addr == cav_pkg::MODULE_VALUE_LOW_OFS[i]) begin
            d.hit   = 1'h1;
            d.high  = 1'h0;
            d.index = 3'(i);
         end
         if (addr == cav_pkg::MODULE_VALUE_HIGH_OFS[i]) begin
            d.hit   = 1'h1;
            d.high  = 1'h1;
            d.index = 3'(i);
         end
      end
      return d;
   endfunction

   function automatic logic [15:0] cycleMask(input logic wide16, input logic [1:0] sel);
      logic [15:0] m;
      m = 16'hffff;
      if (!wide16) begin
         case (sel)
            cav_pkg::CYCLE_8_BITS:  m = 16'h00ff;
            cav_pkg::CYCLE_9_BITS:  m = 16'h01ff;
            cav_pkg::CYCLE_10_BITS: m = 16'h03ff;
            cav_pkg::CYCLE_11_BITS: m = 16'h07ff;
            default:                m = 16'h00ff;
         endcase
      end
      return m;
   endfunction

   cav_pkg::cav_decode_type wrDec;
   cav_pkg::cav_decode_type rdDec;
   logic                    wrCountLow;
   logic                    wrCountHigh;
   logic                    rdCountLow;
   logic                    rdCountHigh;

   assign wrDec       = decodeModule(sfrReq.addr);
   assign rdDec       = wrDec;
   assign wrCountLow  = sfrReq.write && sfrReq.addr == cav_pkg::COUNTER_LOW_BYTE_OFS;
   assign wrCountHigh = sfrReq.write && sfrReq.addr == cav_pkg::COUNTER_HIGH_BYTE_OFS;
   assign rdCountLow  = sfrReq.read && sfrReq.addr == cav_pkg::COUNTER_LOW_BYTE_OFS;
   assign rdCountHigh = sfrReq.read && sfrReq.addr == cav_pkg::COUNTER_HIGH_BYTE_OFS;

   // ****************************************************************
   // Main counter
   // ****************************************************************
   logic [15:0] counter_reg;
   logic [15:0] counter_next;
   logic [7:0]  snapshot_reg;

   always_comb begin
      counter_next = counterTick ? counter_reg + 16'h0001 : counter_reg;
      if (wrCountLow && !watchdogEnable) begin
         counter_next[7:0] = sfrReq.wdata;
      end
      if (wrCountHigh && !watchdogEnable) begin
         counter_next[15:8] = sfrReq.wdata;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         counter_reg <= cav_pkg::COUNTER_RESET;
      end else begin
         counter_reg <= counter_next;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         snapshot_reg <= cav_pkg::BYTE_RESET;
      end else if (rdCountLow) begin
         snapshot_reg <= counter_reg[15:8];
      end
   end

   assign mainCounter = counter_reg;

   // ****************************************************************
   // Module value, reload and comparator enable registers
   // ****************************************************************
   logic [5:0][15:0] compare_reg;
   logic [5:0][15:0] reload_reg;
   logic [5:0]       enable_reg;
   logic [5:0]       match_reg;

   generate
      for (genvar n = 0; n < cav_pkg::MODULE_COUNT; n++) begin : gModule
         logic wrThis;
         logic [15:0] mask;
         assign wrThis = sfrReq.write && wrDec.hit && wrDec.index == 3'(n);
         assign mask   = cycleMask(pwm16Select[n], cycleLengthSelect);

         always_ff @(posedge clk_sys) begin
            if (!rstn) begin
               compare_reg[n] <= cav_pkg::VALUE_RESET;
            end else if (wrThis && !reloadSelect) begin
               if (wrDec.high) begin
                  compare_reg[n][15:8] <= sfrReq.wdata;
               end else begin
                  compare_reg[n][7:0] <= sfrReq.wdata;
               end
            end
         end

         always_ff @(posedge clk_sys) begin
            if (!rstn) begin
               reload_reg[n] <= cav_pkg::VALUE_RESET;
            end else if (wrThis && reloadSelect) begin
               if (wrDec.high) begin
                  reload_reg[n][15:8] <= sfrReq.wdata;
               end else begin
                  reload_reg[n][7:0] <= sfrReq.wdata;
               end
            end
         end

         // Enable side effect applies to value writes, not reload writes
         always_ff @(posedge clk_sys) begin
            if (!rstn) begin
               enable_reg[n] <= 1'h0;
            end else if (wrThis && !reloadSelect) begin
               enable_reg[n] <= wrDec.high;
            end
         end

         always_ff @(posedge clk_sys) begin
            if (!rstn) begin
               match_reg[n] <= 1'h0;
            end else begin
               match_reg[n] <= enable_reg[n] && ((counter_reg & mask) == (compare_reg[n] & mask));
            end
         end
      end
   endgenerate

   assign moduleCompareValue = compare_reg;
   assign moduleReloadValue  = reload_reg;
   assign comparatorEnable   = enable_reg;
   assign matchPulse         = match_reg;

   // ****************************************************************
   // Watchdog ownership of module 5
   // ****************************************************************
   logic watchdog_reg;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         watchdog_reg <= 1'h0;
      end else begin
         watchdog_reg <= watchdogEnable;
      end
   end

   assign watchdogModuleActive = watchdog_reg;

   // ****************************************************************
   // Read data
   // ****************************************************************
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;

   always_comb begin
      rdata_next = 8'h00;
      if (rdCountLow) begin
         rdata_next = counter_reg[7:0];
      end else if (rdCountHigh) begin
         rdata_next = snapshot_reg;
      end else if (sfrReq.read && rdDec.hit) begin
         if (reloadSelect) begin
            rdata_next = rdDec.high ? reload_reg[rdDec.index][15:8] : reload_reg[rdDec.index][7:0];
         end else begin
            rdata_next = rdDec.high ? compare_reg[rdDec.index][15:8] : compare_reg[rdDec.index][7:0];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         rdata_reg <= cav_pkg::BYTE_RESET;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign sfrRdata = rdata_reg;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   sequence lowRead;
      rdCountLow;
   endsequence

   sequence highReadNext;
      rdCountHigh && !rdCountLow;
   endsequence

   chk_snapshot_pair: assert property (
      (lowRead ##1 highReadNext) |=> sfrRdata == $past(counter_reg[15:8], 2))
      else $error("High byte read is not the snapshot of the low byte read");

   chk_low_write_lock: assert property (
      (wrCountLow && watchdogEnable && !counterTick) |=> mainCounter[7:0] == $past(counter_reg[7:0]))
      else $error("Counter low byte changed while watchdog enabled");

   chk_high_write_lock: assert property (
      (wrCountHigh && watchdogEnable && !counterTick && !wrCountLow) |=> mainCounter == $past(counter_reg))
      else $error("Counter high byte changed while watchdog enabled");

   chk_low_write_take: assert property (
      (wrCountLow && !watchdogEnable) |=> mainCounter[7:0] == $past(sfrReq.wdata))
      else $error("Counter low byte write not taken");

   chk_high_write_take: assert property (
      (wrCountHigh && !watchdogEnable) |=> mainCounter[15:8] == $past(sfrReq.wdata))
      else $error("Counter high byte write not taken");

   chk_low_clears_enable: assert property (
      (sfrReq.write && wrDec.hit && !wrDec.high && !reloadSelect) |=> !comparatorEnable[$past(wrDec.index)])
      else $error("Low byte write did not clear comparator enable");

   chk_high_sets_enable: assert property (
      (sfrReq.write && wrDec.hit && wrDec.high && !reloadSelect) |=> comparatorEnable[$past(wrDec.index)])
      else $error("High byte write did not set comparator enable");

   chk_reload_route: assert property (
      (sfrReq.write && wrDec.hit && reloadSelect) |=> $stable(moduleCompareValue))
      else $error("Reload write reached compare value");

   chk_compare_low_read: assert property (
      (sfrReq.read && wrDec.hit && !wrDec.high && !reloadSelect && !sfrReq.write)
         |=> sfrRdata == $past(compare_reg[wrDec.index][7:0]))
      else $error("Module low byte read mismatch");

   chk_match_disabled: assert property (
      !enable_reg[0] |=> !matchPulse[0])
      else $error("Match reported with comparator disabled");

   chk_watchdog_follow: assert property (
      watchdogEnable ##1 watchdogEnable |-> watchdogModuleActive)
      else $error("Module 5 watchdog flag did not follow enable");

endmodule

// ---- test/cav_sfr_master.sv ----
`timescale 1ns/1ns
module cav_sfr_master (
   input  wire logic                clk_sys,
   output cav_pkg::cav_sfr_req_type sfrReq,
   input  wire logic [7:0]          sfrRdata
);
   // ********
   // Core side of the register bus
   // ********
   initial begin
      sfrReq = '0;
   end

   // A released bus shows the inverse of the last request, never a stale copy
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      @(posedge clk_sys);
      sfrReq <= '{addr: addr, write: 1'h1, read: 1'h0, wdata: data};
      @(posedge clk_sys);
      sfrReq <= '{addr: ~addr, write: 1'h0, read: 1'h0, wdata: ~data};
      #1;
   endtask

   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
      @(posedge clk_sys);
      sfrReq <= '{addr: addr, write: 1'h0, read: 1'h1, wdata: ~sfrReq.wdata};
      @(posedge clk_sys);
      sfrReq <= '{addr: ~addr, write: 1'h0, read: 1'h0, wdata: ~sfrReq.wdata};
      #1;
      data = sfrRdata;
   endtask

   // Two reads on adjacent edges, the strobe held up between them
   task automatic read_pair(input logic [7:0] addrA, input logic [7:0] addrB,
                            output logic [7:0] dataA, output logic [7:0] dataB);
      @(posedge clk_sys);
      sfrReq <= '{addr: addrA, write: 1'h0, read: 1'h1, wdata: ~sfrReq.wdata};
      @(posedge clk_sys);
      sfrReq <= '{addr: addrB, write: 1'h0, read: 1'h1, wdata: sfrReq.wdata};
      #1;
      dataA = sfrRdata;
      @(posedge clk_sys);
      sfrReq <= '{addr: ~addrB, write: 1'h0, read: 1'h0, wdata: ~sfrReq.wdata};
      #1;
      dataB = sfrRdata;
   endtask
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/1ns
module testbench;
   // ********
   // Signals
   // ********
   logic                     clk_sys;
   logic                     rstn;
   cav_pkg::cav_sfr_req_type sfrReq;
   logic [7:0]               sfrRdata;
   logic                     watchdogEnable;
   logic                     reloadSelect;
   logic [1:0]               cycleLengthSelect;
   logic [5:0]               pwm16Select;
   logic                     counterTick;
   logic [15:0]              mainCounter;
   logic [5:0][15:0]         moduleCompareValue;
   logic [5:0][15:0]         moduleReloadValue;
   logic [5:0]               comparatorEnable;
   logic [5:0]               matchPulse;
   logic                     watchdogModuleActive;
   logic [5:0][15:0]         cmpExp;
   logic [5:0][15:0]         rldExp;
   logic [15:0]              cnt;
   logic [15:0]              cmp;
   logic [7:0]               lo;
   logic [7:0]               hi;
   int                       fails;
   int                       checks;

   cav_counter_array_value_regs cav_counter_array_value_regs_i (
      .clk_sys(clk_sys), .rstn(rstn), .sfrReq(sfrReq), .sfrRdata(sfrRdata),
      .watchdogEnable(watchdogEnable), .reloadSelect(reloadSelect),
      .cycleLengthSelect(cycleLengthSelect), .pwm16Select(pwm16Select),
      .counterTick(counterTick), .mainCounter(mainCounter),
      .moduleCompareValue(moduleCompareValue), .moduleReloadValue(moduleReloadValue),
      .comparatorEnable(comparatorEnable), .matchPulse(matchPulse),
      .watchdogModuleActive(watchdogModuleActive)
   );

   cav_sfr_master cav_sfr_master_i (.clk_sys(clk_sys), .sfrReq(sfrReq), .sfrRdata(sfrRdata));

   // ********
   // Helpers
   // ********
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      if (fails == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      cav_sfr_master_i.write_reg(a, d);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      cav_sfr_master_i.read_reg(a, d);
      check({8'h00, d}, {8'h00, e});
   endtask

   // Masked compare as seen by the match logic
   function automatic logic exp_match(logic [15:0] c, logic [15:0] v, logic [1:0] cl, logic p16);
      logic [15:0] mask;
      mask = p16 ? 16'hffff : 16'hffff >> (4'h8 - {2'h0, cl});
      return ((c ^ v) & mask) == 16'h0000;
   endfunction

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   // ********
   // Tests
   // ********
   initial begin
      void'($urandom(32'h96e7));
      rstn = 1'h0;
      watchdogEnable = 1'h0;
      reloadSelect = 1'h0;
      cycleLengthSelect = 2'h0;
      pwm16Select = 6'h00;
      counterTick = 1'h0;
      cmpExp = '0;
      rldExp = '0;
      fails = 0;
      checks = 0;
      repeat (4) @(posedge clk_sys);
      rstn <= 1'h1;
      rdchk(cav_pkg::COUNTER_LOW_BYTE_OFS, 8'h00);
      rdchk(cav_pkg::COUNTER_HIGH_BYTE_OFS, 8'h00);
      for (int n = 0; n < 6; n++) begin
         rdchk(cav_pkg::MODULE_VALUE_LOW_OFS[n], 8'h00);
         rdchk(cav_pkg::MODULE_VALUE_HIGH_OFS[n], 8'h00);
      end
      // Random values into both banks, high byte first so the enable side effects show
      for (int s = 0; s < 2; s++) begin
         @(posedge clk_sys);
         reloadSelect <= s[0];
         for (int n = 0; n < 6; n++) begin
            lo = 8'($urandom);
            hi = 8'($urandom);
            wr(cav_pkg::MODULE_VALUE_HIGH_OFS[n], hi);
            check({15'h0, comparatorEnable[n]}, 16'(s == 0));
            wr(cav_pkg::MODULE_VALUE_LOW_OFS[n], lo);
            check({15'h0, comparatorEnable[n]}, 16'h0000);
            if (s == 0)
               cmpExp[n] = {hi, lo};
            else
               rldExp[n] = {hi, lo};
            check(moduleCompareValue[n], cmpExp[n]);
            check(moduleReloadValue[n], rldExp[n]);
         end
      end
      for (int s = 0; s < 2; s++) begin
         @(posedge clk_sys);
         reloadSelect <= s[0];
         for (int n = 0; n < 6; n++) begin
            cmp = s ? rldExp[n] : cmpExp[n];
            rdchk(cav_pkg::MODULE_VALUE_LOW_OFS[n], cmp[7:0]);
            rdchk(cav_pkg::MODULE_VALUE_HIGH_OFS[n], cmp[15:8]);
         end
      end
      @(posedge clk_sys);
      reloadSelect <= 1'h0;
      // Counter writes, then inverted writes with the watchdog on
      cnt = 16'($urandom);
      wr(cav_pkg::COUNTER_LOW_BYTE_OFS, cnt[7:0]);
      wr(cav_pkg::COUNTER_HIGH_BYTE_OFS, cnt[15:8]);
      check(mainCounter, cnt);
      @(posedge clk_sys);
      watchdogEnable <= 1'h1;
      @(posedge clk_sys);
      #1;
      check({15'h0, watchdogModuleActive}, 16'h0001);
      wr(cav_pkg::COUNTER_LOW_BYTE_OFS, ~cnt[7:0]);
      wr(cav_pkg::COUNTER_HIGH_BYTE_OFS, ~cnt[15:8]);
      check(mainCounter, cnt);
      @(posedge clk_sys);
      watchdogEnable <= 1'h0;
      // Snapshot across a carry into the high byte
      cnt = {8'($urandom), 8'hff};
      wr(cav_pkg::COUNTER_LOW_BYTE_OFS, cnt[7:0]);
      wr(cav_pkg::COUNTER_HIGH_BYTE_OFS, cnt[15:8]);
      rdchk(cav_pkg::COUNTER_LOW_BYTE_OFS, 8'hff);
      @(posedge clk_sys);
      counterTick <= 1'h1;
      @(posedge clk_sys);
      counterTick <= 1'h0;
      #1;
      check(mainCounter, cnt + 16'h0001);
      rdchk(cav_pkg::COUNTER_HIGH_BYTE_OFS, cnt[15:8]);
      rdchk(cav_pkg::COUNTER_LOW_BYTE_OFS, 8'h00);
      rdchk(cav_pkg::COUNTER_HIGH_BYTE_OFS, cnt[15:8] + 8'h01);
      rdchk(8'h00, 8'h00);
      cnt = cnt + 16'h0001;
      // Back-to-back low and high read while counting, carry between them
      wr(cav_pkg::COUNTER_LOW_BYTE_OFS, 8'hfe);
      cnt[7:0] = 8'hfe;
      @(posedge clk_sys);
      counterTick <= 1'h1;
      cav_sfr_master_i.read_pair(cav_pkg::COUNTER_LOW_BYTE_OFS, cav_pkg::COUNTER_HIGH_BYTE_OFS, lo, hi);
      check({8'h00, lo}, 16'h00ff);
      check({8'h00, hi}, {8'h00, cnt[15:8]});
      @(posedge clk_sys);
      counterTick <= 1'h0;
      cnt = cnt + 16'h0004;
      #1;
      check(mainCounter, cnt);
      // Match against one-bit differences for every cycle length
      for (int k = 0; k < 8; k++) begin
         @(posedge clk_sys);
         cycleLengthSelect <= k[1:0];
         pwm16Select <= {5'($urandom), k[2]};
         cmp = cnt ^ (16'h0001 << (8 + $urandom_range(7)));
         wr(cav_pkg::MODULE_VALUE_LOW_OFS[0], cmp[7:0]);
         wr(cav_pkg::MODULE_VALUE_HIGH_OFS[0], cmp[15:8]);
         repeat (3) @(posedge clk_sys);
         #1;
         check({15'h0, matchPulse[0]}, 16'(exp_match(cnt, cmp, k[1:0], k[2])));
      end
      wr(cav_pkg::MODULE_VALUE_LOW_OFS[0], cnt[7:0]);
      repeat (3) @(posedge clk_sys);
      #1;
      check({15'h0, matchPulse[0]}, 16'h0000);
      give_verdict();
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      fails++;
      give_verdict();
   end
endmodule
